// ==== design/xrs_pkg.sv ====
// Package: constants and carrier types for the transceiver reset sequencer
package xrs_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 32;
    localparam logic [3:0]  REG_RECFG    = 4'h0;  // Reconfig kind and go
    localparam logic [3:0]  REG_STATUS   = 4'h4;  // Live indications
    localparam logic [3:0]  REG_TOGGLES  = 4'h8;  // Phy-done toggle count

    // Reconfig register fields
    localparam int          KIND_LSB     = 0;
    localparam int          KIND_W       = 3;
    localparam int          GO_BIT       = 8;
    localparam logic [2:0]  KIND_RESET   = 3'h0;

    // Status register fields
    localparam int          ST_PLL_LOCK  = 0;
    localparam int          ST_BUSY      = 1;
    localparam int          ST_CDR_LOCK  = 2;
    localparam int          ST_CFG_DONE  = 3;
    localparam int          ST_SCAN_BUSY = 4;
    localparam int          ST_PHY_DONE  = 5;
    localparam int          ST_ASLEEP    = 6;

    localparam int          TOG_W        = 8;

    // ------------------------------------------------------------------
    // Timing: times in ns, counts derived from the clock period
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned OCAL_TIME_NS  = 20000;
    localparam int unsigned RECFG_TIME_NS = 1000;
    localparam int unsigned PLL_LOCK_NS   = 10000;
    localparam int unsigned CDR_LOCK_NS   = 5000;
    localparam int unsigned SCAN_BITS     = 144;   // One bit per cycle
    localparam int unsigned OCAL_CYC  =
        (OCAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECFG_CYC =
        (RECFG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PLL_CYC   =
        (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CDR_CYC   =
        (CDR_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SCAN_CYC  = SCAN_BITS;
    localparam int          TMR_W     = 16;

    // Timer slots
    localparam int T_OCAL  = 0;
    localparam int T_RECFG = 1;
    localparam int T_SCAN  = 2;
    localparam int T_PLL   = 3;
    localparam int T_CDR   = 4;
    localparam int NUM_T   = 5;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        XRS_OCAL  = 2'b00,
        XRS_IDLE  = 2'b01,
        XRS_RECFG = 2'b10
    } xrs_eng_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } xrs_bus_req_s;

    typedef struct packed {
        logic txpll;
        logic tx_logic;
        logic rx_analog;
        logic rx_logic;
    } xrs_rst_s;

    typedef struct packed {
        logic txpll_lock_ind;
        logic busy;
        logic cdr_data_lock;
        logic chan_cfg_done;
        logic scan_chain_done;
        logic phy_done_ind;
        logic powered_down;
    } xrs_ind_s;

endpackage : xrs_pkg

// ==== design/xrs_seq.sv ====
// Module: transceiver-side model of reset, lock and reconfig indications
//
// Our own choices: the address-and-strobe port and the register addresses.
module xrs_seq #(
    parameter int unsigned OCAL_CYC  = xrs_pkg::OCAL_CYC,   // Offset cancel
    parameter int unsigned RECFG_CYC = xrs_pkg::RECFG_CYC,  // Channel reconfig
    parameter int unsigned SCAN_CYC  = xrs_pkg::SCAN_CYC,   // Scan shift
    parameter int unsigned PLL_CYC   = xrs_pkg::PLL_CYC,    // PLL lock time
    parameter int unsigned CDR_CYC   = xrs_pkg::CDR_CYC     // CDR lock time
) (
    input  wire logic                 ref_clk,          // Core clock
    input  wire logic                 rst_n,            // Async reset, low
    input  wire logic                 ce,               // Clock enable
    input  wire xrs_pkg::xrs_bus_req_s bus_req,         // Register request
    output logic [xrs_pkg::DATA_W-1:0] bus_rdata,       // Read data, next cycle
    input  wire xrs_pkg::xrs_rst_s    rst_in,           // Resets from fabric
    input  wire logic                 pll_cfg_apply,    // Apply from PLL cfg
    input  wire logic                 xcvr_block_sleep, // Block power down
    input  wire logic                 rx_sig_present,   // Serial data pin
    output xrs_pkg::xrs_ind_s         ind,              // Status indications
    output logic [xrs_pkg::KIND_W-1:0] reconfig_kind_sel // Selected kind
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        xrs_pkg::xrs_eng_e              eng;
        logic                           busy;
        logic                           cfg_done;
        logic                           scan_busy;
        logic                           scan_done;
        logic                           pll_lock;
        logic                           cdr_lock;
        logic                           phy_done;
        logic                           asleep;
        logic                           rxl_q;
        logic                           apply_q;
        logic                           sig_s1;
        logic                           sig_s2;
        logic [xrs_pkg::KIND_W-1:0]     kind;
        logic [xrs_pkg::TOG_W-1:0]      toggles;
        logic [xrs_pkg::DATA_W-1:0]     rdata;
    } xrs_state_s;

    xrs_state_s r_reg;
    xrs_state_s r_next;

    logic [xrs_pkg::NUM_T-1:0] t_run;
    logic [xrs_pkg::NUM_T-1:0] t_done;

    localparam int unsigned LIM [xrs_pkg::NUM_T] =
        '{OCAL_CYC, RECFG_CYC, SCAN_CYC, PLL_CYC, CDR_CYC};

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Write hit on one register word
    function automatic logic wr_hit(input xrs_pkg::xrs_bus_req_s q,
                                    input logic [xrs_pkg::ADDR_W-1:0] a);
        wr_hit = q.wr && (q.addr == a);
    endfunction

    // Read hit on one register word
    function automatic logic rd_hit(input xrs_pkg::xrs_bus_req_s q,
                                    input logic [xrs_pkg::ADDR_W-1:0] a);
        rd_hit = q.rd && (q.addr == a);
    endfunction

    // ------------------------------------------------------------------
    // Timers, one per timed activity
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < xrs_pkg::NUM_T; gi++) begin : g_tmr
            xrs_timer #(
                .LIMIT (LIM[gi]),
                .W     (xrs_pkg::TMR_W)
            ) u_tmr (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .ce      (ce),
                .run     (t_run[gi]),
                .done    (t_done[gi])
            );
        end
    endgenerate

    // Run conditions; sleep stops every analog activity
    always_comb begin
        t_run          = '0;
        t_run[xrs_pkg::T_OCAL]  = (r_reg.eng == xrs_pkg::XRS_OCAL)
                                  && !xcvr_block_sleep;
        t_run[xrs_pkg::T_RECFG] = (r_reg.eng == xrs_pkg::XRS_RECFG);
        t_run[xrs_pkg::T_SCAN]  = r_reg.scan_busy;
        t_run[xrs_pkg::T_PLL]   = !rst_in.txpll
                                  && !xcvr_block_sleep;
        t_run[xrs_pkg::T_CDR]   = r_reg.pll_lock && !rst_in.rx_analog
                                  && r_reg.sig_s2
                                  && !xcvr_block_sleep;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic go;
    logic apply_rise;

    always_comb begin
        r_next     = r_reg;
        go         = wr_hit(bus_req, xrs_pkg::REG_RECFG)
                     && bus_req.wdata[xrs_pkg::GO_BIT];
        apply_rise = pll_cfg_apply && !r_reg.apply_q;

        // Data pin is asynchronous: two flops before anything looks at it
        r_next.sig_s1  = rx_sig_present;
        r_next.sig_s2  = r_reg.sig_s1;
        r_next.rxl_q   = rst_in.rx_logic;
        r_next.apply_q = pll_cfg_apply;
        r_next.asleep  = xcvr_block_sleep;

        // Kind field follows a write to the reconfig word unless a reconfig is running
        if (wr_hit(bus_req, xrs_pkg::REG_RECFG) &&
            (r_reg.eng != xrs_pkg::XRS_RECFG)) begin
            r_next.kind = bus_req.wdata[xrs_pkg::KIND_LSB +:
                                        xrs_pkg::KIND_W];
        end

        // Reconfig engine; go is ignored while already busy
        case (r_reg.eng)
            xrs_pkg::XRS_OCAL: begin
                if (t_done[xrs_pkg::T_OCAL]) begin
                    r_next.eng = xrs_pkg::XRS_IDLE;
                end
            end
            xrs_pkg::XRS_IDLE: begin
                if (go && !xcvr_block_sleep) begin
                    r_next.eng      = xrs_pkg::XRS_RECFG;
                    r_next.cfg_done = 1'b0;
                end
            end
            xrs_pkg::XRS_RECFG: begin
                if (t_done[xrs_pkg::T_RECFG]) begin
                    r_next.eng      = xrs_pkg::XRS_IDLE;
                    r_next.cfg_done = 1'b1;
                end
            end
            default: begin
                r_next.eng = xrs_pkg::XRS_IDLE;
            end
        endcase
        r_next.busy = (r_next.eng != xrs_pkg::XRS_IDLE);

        // Scan shift: done is a one-cycle pulse at the end
        r_next.scan_done = 1'b0;
        if (r_reg.scan_busy && t_done[xrs_pkg::T_SCAN]) begin
            r_next.scan_busy = 1'b0;
            r_next.scan_done = 1'b1;
        end else if (apply_rise && !xcvr_block_sleep) begin
            r_next.scan_busy = 1'b1;
        end

        // Lock indications, dropped by reset or sleep via the run terms
        r_next.pll_lock = t_done[xrs_pkg::T_PLL];
        r_next.cdr_lock = t_done[xrs_pkg::T_CDR];

        // Each release of receive logic reset outside sleep flips the status level
        if (r_reg.rxl_q && !rst_in.rx_logic && !xcvr_block_sleep) begin
            r_next.phy_done = ~r_reg.phy_done;
            r_next.toggles  = r_reg.toggles + xrs_pkg::TOG_W'(1);
        end

        // Read data stands only in the cycle after the strobe
        r_next.rdata = '0;
        if (rd_hit(bus_req, xrs_pkg::REG_RECFG)) begin
            r_next.rdata[xrs_pkg::KIND_LSB +: xrs_pkg::KIND_W] = r_reg.kind;
            r_next.rdata[xrs_pkg::GO_BIT] = r_reg.busy;
        end else if (rd_hit(bus_req, xrs_pkg::REG_STATUS)) begin
            r_next.rdata[xrs_pkg::ST_PLL_LOCK]  = r_reg.pll_lock;
            r_next.rdata[xrs_pkg::ST_BUSY]      = r_reg.busy;
            r_next.rdata[xrs_pkg::ST_CDR_LOCK]  = r_reg.cdr_lock;
            r_next.rdata[xrs_pkg::ST_CFG_DONE]  = r_reg.cfg_done;
            r_next.rdata[xrs_pkg::ST_SCAN_BUSY] = r_reg.scan_busy;
            r_next.rdata[xrs_pkg::ST_PHY_DONE]  = r_reg.phy_done;
            r_next.rdata[xrs_pkg::ST_ASLEEP]    = r_reg.asleep;
        end else if (rd_hit(bus_req, xrs_pkg::REG_TOGGLES)) begin
            r_next.rdata[xrs_pkg::TOG_W-1:0] = r_reg.toggles;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Busy comes up high: offset cancellation runs from power up
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg      <= '0;
            r_reg.eng  <= xrs_pkg::XRS_OCAL;
            r_reg.busy <= 1'b1;
            r_reg.kind <= xrs_pkg::KIND_RESET;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign bus_rdata             = r_reg.rdata;
    assign reconfig_kind_sel     = r_reg.kind;
    // One driver for the whole indication struct
    assign ind = '{
        txpll_lock_ind:  r_reg.pll_lock,
        busy:            r_reg.busy,
        cdr_data_lock:   r_reg.cdr_lock,
        chan_cfg_done:   r_reg.cfg_done,
        scan_chain_done: r_reg.scan_done,
        phy_done_ind:    r_reg.phy_done,
        powered_down:    r_reg.asleep
    };

endmodule // xrs_seq

// ==== design/xrs_timer.sv ====
// Module: run-length timer that flags a fixed number of running cycles
module xrs_timer #(
    parameter int unsigned LIMIT = 1,   // Cycles of run before done
    parameter int          W     = 16   // Counter width
) (
    input  wire logic ref_clk,          // Core clock
    input  wire logic rst_n,            // Async reset, active low
    input  wire logic ce,               // Clock enable
    input  wire logic run,              // Count while high, clear when low
    output logic      done              // High once LIMIT cycles have run
);

    localparam logic [W-1:0] LIM_M1 = W'(LIMIT - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } xrs_tmr_s;

    xrs_tmr_s r_reg;
    xrs_tmr_s r_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Counter saturates so done holds for as long as run stays high
    always_comb begin
        r_next = r_reg;
        if (!run) begin
            r_next.cnt  = '0;
            r_next.done = 1'b0;
        end else if (!r_reg.done) begin
            r_next.cnt  = r_reg.cnt + W'(1);
            r_next.done = (r_reg.cnt == LIM_M1);
        end
    end

    // Registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign done = r_reg.done;

endmodule // xrs_timer

// ==== dv/xrs_fab.sv ====
// Model: fabric reset controller driving the transceiver resets
module xrs_fab #(
    parameter int unsigned US_CYC  = 100,  // One microsecond in cycles
    parameter int unsigned LTD_CYC = 8     // Lock-to-data wait, cycles
) (
    input  wire logic          ref_clk,          // Core clock
    input  wire xrs_pkg::xrs_ind_s ind,          // Indications seen
    output xrs_pkg::xrs_rst_s  rst_in,           // Resets to transceiver
    output logic               pll_cfg_apply,    // Scan apply
    output logic               xcvr_block_sleep  // Block power down
);
    timeunit 1ns;
    timeprecision 1ps;

    // Everything held in reset from time zero
    initial begin
        rst_in = '1;
        pll_cfg_apply = 1'b0;
        xcvr_block_sleep = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Bounded wait for one indication; values seen before the edge lands
    task automatic wait_ind(input int sel, input logic lvl);
        int   k;
        logic v;
        k = 0;
        v = ~lvl;
        while (v !== lvl && k < 4000) begin
            @(posedge ref_clk);
            case (sel)
                0: v = ind.txpll_lock_ind;
                1: v = ind.cdr_data_lock;
                2: v = ind.busy;
                3: v = ind.chan_cfg_done;
                default: v = ind.scan_chain_done;
            endcase
            k++;
        end
    endtask

    // Lock wait counted, not timed, so short runs stay exact
    task automatic after_cdr();
        wait_ind(1, 1'b1);
        tick(LTD_CYC);
        rst_in.rx_logic <= 1'b0;
    endtask

    task automatic power_up();
        tick(US_CYC);
        rst_in.txpll <= 1'b0;
        wait_ind(0, 1'b1);
        rst_in.tx_logic <= 1'b0;
        wait_ind(2, 1'b0);
        tick(2);
        rst_in.rx_analog <= 1'b0;
        rst_in.rx_logic <= 1'b0;
    endtask

    task automatic relock();
        wait_ind(1, 1'b1);
        tick(LTD_CYC);
        rst_in.rx_logic <= 1'b1;
        tick(2);
        rst_in.rx_logic <= 1'b0;
    endtask

    task automatic hold_all();
        rst_in.tx_logic <= 1'b1;
        rst_in.rx_analog <= 1'b1;
        rst_in.rx_logic <= 1'b1;
        tick(1);
    endtask

    task automatic pll_recfg();
        hold_all();
        pll_cfg_apply <= 1'b1;
        tick(1);
        pll_cfg_apply <= 1'b0;
        wait_ind(4, 1'b1);
        rst_in.txpll <= 1'b1;
        tick(US_CYC);
        rst_in.txpll <= 1'b0;
        wait_ind(0, 1'b1);
        rst_in.tx_logic <= 1'b0;
        tick(5);
        rst_in.rx_analog <= 1'b0;
        after_cdr();
    endtask

    task automatic release_cfg();
        wait_ind(3, 1'b1);
        rst_in.tx_logic <= 1'b0;
        tick(5);
        rst_in.rx_analog <= 1'b0;
        after_cdr();
    endtask

    task automatic sleep_pulse();
        wait_ind(2, 1'b0);
        xcvr_block_sleep <= 1'b1;
        tick(US_CYC);
        xcvr_block_sleep <= 1'b0;
    endtask
endmodule // xrs_fab

// ==== dv/xrs_seq_bench.sv ====
// Testbench: register and reset-sequence scenarios for the sequencer
module xrs_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                           ref_clk;
    logic                           rst_n;
    logic                           ce;
    xrs_pkg::xrs_bus_req_s          bus_req;
    logic [xrs_pkg::DATA_W-1:0]     bus_rdata;
    xrs_pkg::xrs_rst_s              rst_in;
    logic                           pll_cfg_apply;
    logic                           xcvr_block_sleep;
    logic                           rx_sig_present;
    xrs_pkg::xrs_ind_s              ind;
    logic [xrs_pkg::KIND_W-1:0]     reconfig_kind_sel;
    int                             mismatches = 0;
    int                             n_compared = 0;

    // Short counts keep the run small
    xrs_seq #(.OCAL_CYC(20), .RECFG_CYC(8), .SCAN_CYC(6), .PLL_CYC(10),
        .CDR_CYC(6)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .rst_in(rst_in),
        .pll_cfg_apply(pll_cfg_apply), .xcvr_block_sleep(xcvr_block_sleep),
        .rx_sig_present(rx_sig_present), .ind(ind),
        .reconfig_kind_sel(reconfig_kind_sel));

    xrs_fab fab_u (
        .ref_clk(ref_clk), .ind(ind), .rst_in(rst_in),
        .pll_cfg_apply(pll_cfg_apply), .xcvr_block_sleep(xcvr_block_sleep));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Gap edge after the strobe so no signal is assigned twice at once
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Data taken mid-cycle, while it stands after the strobe edge
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        @(negedge ref_clk);
        check(bus_rdata, exp);
        @(posedge ref_clk);
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        bus_req = '0;
        rx_sig_present = 1'b1;
        idle(4);
        rst_n <= 1'b1;
        idle(1);
        // Go refused during offset cancel, kind still taken
        rd_chk(xrs_pkg::REG_STATUS, 32'h0000_0002);
        wr(xrs_pkg::REG_RECFG, 32'h0000_0105);
        rd_chk(xrs_pkg::REG_RECFG, 32'h0000_0105);
        fab_u.power_up();
        idle(3);
        rd_chk(xrs_pkg::REG_TOGGLES, 32'h0000_0001);
        fab_u.wait_ind(1, 1'b1);
        rd_chk(xrs_pkg::REG_STATUS, 32'h0000_0025);
        wr(4'hC, 32'hFFFF_FFFF);
        rd_chk(4'hC, 32'h0000_0000);
        rd_chk(xrs_pkg::REG_RECFG, 32'h0000_0005);
        // Lock loss in normal phase, then relock and short pulse
        rx_sig_present <= 1'b0;
        fab_u.wait_ind(1, 1'b0);
        rx_sig_present <= 1'b1;
        fab_u.relock();
        idle(3);
        rd_chk(xrs_pkg::REG_TOGGLES, 32'h0000_0002);
        // Data-rate change through the scan chain
        fab_u.pll_recfg();
        idle(3);
        rd_chk(xrs_pkg::REG_STATUS, 32'h0000_0025);
        // Channel reconfig; a second go while busy is dropped
        fab_u.hold_all();
        wr(xrs_pkg::REG_RECFG, 32'h0000_0003);
        wr(xrs_pkg::REG_RECFG, 32'h0000_0103);
        wr(xrs_pkg::REG_RECFG, 32'h0000_0106);
        rd_chk(xrs_pkg::REG_RECFG, 32'h0000_0103);
        fab_u.release_cfg();
        idle(3);
        rd_chk(xrs_pkg::REG_STATUS, 32'h0000_000D);
        rd_chk(xrs_pkg::REG_TOGGLES, 32'h0000_0004);
        // Block sleep drops both locks, relock after wake
        fork
            fab_u.sleep_pulse();
            begin
                idle(5);
                rd_chk(xrs_pkg::REG_STATUS, 32'h0000_0048);
            end
        join
        fab_u.wait_ind(1, 1'b1);
        rd_chk(xrs_pkg::REG_STATUS, 32'h0000_000D);
        // Enable low: a go written then must leave no trace
        ce <= 1'b0;
        wr(xrs_pkg::REG_RECFG, 32'h0000_0104);
        ce <= 1'b1;
        rd_chk(xrs_pkg::REG_RECFG, 32'h0000_0003);
        check(32'(reconfig_kind_sel), 32'h0000_0003);
        print_verdict();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        idle(30000);
        mismatches++;
        print_verdict();
    end
endmodule // xrs_seq_bench

// ==== dv/xrs_seq_sva.sv ====
// Checker: port-level properties of the transceiver reset sequencer
module xrs_seq_chk #(
    parameter int unsigned OCAL_CYC  = 20,  // Offset cancel cycles
    parameter int unsigned RECFG_CYC = 8,   // Channel reconfig cycles
    parameter int unsigned SCAN_CYC  = 6,   // Scan shift cycles
    parameter int unsigned PLL_CYC   = 10,  // PLL lock cycles
    parameter int unsigned CDR_CYC   = 6    // CDR lock cycles
) (
    input wire logic                      ref_clk,           // Core clock
    input wire logic                      rst_n,             // Async reset
    input wire logic                      ce,                // Clock enable
    input wire xrs_pkg::xrs_bus_req_s     bus_req,           // Bus request
    input wire logic [xrs_pkg::DATA_W-1:0] bus_rdata,        // Read data
    input wire xrs_pkg::xrs_rst_s         rst_in,            // Fabric resets
    input wire logic                      pll_cfg_apply,     // Scan apply
    input wire logic                      xcvr_block_sleep,  // Power down
    input wire logic                      rx_sig_present,    // Serial pin
    input wire xrs_pkg::xrs_ind_s         ind,               // Indications
    input wire logic [xrs_pkg::KIND_W-1:0] reconfig_kind_sel // Kind
);
    // Timer done is a flop, and the flag it sets is one more flop behind
    localparam int SCAN_D = int'(SCAN_CYC) + 2;
    localparam int RC_D   = int'(RECFG_CYC) + 1;
    localparam int PLL_D  = int'(PLL_CYC) + 1;

    // ------------------------------------------------------------------
    // Helper: edges since reset release, saturating
    // ------------------------------------------------------------------
    logic [15:0] run_cnt_reg;
    logic        go_ok;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt_reg <= 16'h0000;
        end else if (run_cnt_reg != 16'hFFFF) begin
            run_cnt_reg <= run_cnt_reg + 16'h0001;
        end
    end
    // Go only counts when the engine is idle and awake
    assign go_ok = ce && bus_req.wr && bus_req.addr == xrs_pkg::REG_RECFG
        && bus_req.wdata[xrs_pkg::GO_BIT] && !ind.busy && !xcvr_block_sleep;

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_pll_rise;
        $rose(ind.txpll_lock_ind) |->
            !$past(rst_in.txpll, PLL_D) && !$past(xcvr_block_sleep, PLL_D);
    endproperty
    a_pll_rise: assert property (p_pll_rise)
        else $error("pll lock rose without a full lock wait");
    property p_pll_fall;
        rst_in.txpll |-> ##2 !ind.txpll_lock_ind;
    endproperty
    a_pll_fall: assert property (p_pll_fall)
        else $error("pll lock held during pll reset");
    property p_scan;
        $rose(pll_cfg_apply) |->
            ##SCAN_D ind.scan_chain_done ##1 !ind.scan_chain_done;
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan done pulse late, early or long");
    property p_go_busy;
        go_ok |=> ind.busy && !ind.chan_cfg_done;
    endproperty
    a_go_busy: assert property (p_go_busy)
        else $error("go did not start the engine");
    property p_go_done;
        go_ok |=> ##RC_D ind.chan_cfg_done && !ind.busy;
    endproperty
    a_go_done: assert property (p_go_done)
        else $error("reconfig done not on time");
    property p_ocal_hi;
        run_cnt_reg < OCAL_CYC |-> ind.busy;
    endproperty
    a_ocal_hi: assert property (p_ocal_hi)
        else $error("busy fell before offset cancel ended");
    property p_ocal_lo;
        run_cnt_reg == OCAL_CYC + 2 |-> !ind.busy;
    endproperty
    a_ocal_lo: assert property (p_ocal_lo)
        else $error("busy stuck after offset cancel");
    property p_phy_flip;
        $fell(rst_in.rx_logic) && !xcvr_block_sleep |=>
            $changed(ind.phy_done_ind);
    endproperty
    a_phy_flip: assert property (p_phy_flip)
        else $error("phy done did not toggle");
    property p_phy_hold;
        !$fell(rst_in.rx_logic) |=> $stable(ind.phy_done_ind);
    endproperty
    a_phy_hold: assert property (p_phy_hold)
        else $error("phy done toggled without cause");
    property p_sleep;
        xcvr_block_sleep |=> ind.powered_down ##1 (!ind.txpll_lock_ind
            && !ind.cdr_data_lock);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("block not powered down in sleep");

    // Main scenarios reached
    c_go: cover property (go_ok);
    c_scan: cover property (ind.scan_chain_done);
    c_sleep: cover property ($rose(xcvr_block_sleep));
endmodule // xrs_seq_chk

bind xrs_seq xrs_seq_chk #(
    .OCAL_CYC(OCAL_CYC), .RECFG_CYC(RECFG_CYC), .SCAN_CYC(SCAN_CYC),
    .PLL_CYC(PLL_CYC), .CDR_CYC(CDR_CYC)
) chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .rst_in(rst_in), .pll_cfg_apply(pll_cfg_apply),
    .xcvr_block_sleep(xcvr_block_sleep), .rx_sig_present(rx_sig_present),
    .ind(ind), .reconfig_kind_sel(reconfig_kind_sel)
);
